// file: design/watchdog_timer_unit.sv
// Watchdog timer unit with APB register slave
//
// Overview of operation
// - Thirty-bit counter, usable as supervisor or general event timer.
// - Expiry gives interrupt request, system reset, or both per control bits.
// - Counts on CPU clock; halts in idle and stop; slower in slow clock mode.
// - Expiry flag set on every timeout regardless of interrupt enable.
// - Expiry flag sticky until software writes zero; software clears after service.
// - Expiry reaches CPU interrupt only with enable bit 4 of extended enable.
// - Reset flag set by watchdog-caused reset, untouched by software reset.
// - Reset flag cleared by software zero write or external reset pin.
// - Reset enable one: timeout resets system; zero: flag and interrupt only.
// - After power-up reset enabled and longest timeout selected.
// - Restart write clears count only while timed-access lock is open.
// - Timeout select in clock config bits 7, 6 and top bit 2.
//
// The APB register port was decided locally.
`timescale 1ns/1ps
module watchdog_timer_unit
   import wdog_pkg::*;
#(
   parameter int TIMEOUT_SHRINK = 0
) (
   // Clock and reset
   input  wire logic              core_clk_in,
   input  wire logic              rst_in,
   // APB slave
   input  wire logic              psel_in,
   input  wire logic              penable_in,
   input  wire logic              pwrite_in,
   input  wire logic [ADDR_W-1:0] paddr_in,
   input  wire logic [31:0]       pwdata_in,
   output logic [31:0]            prdata_out,
   output logic                   pready_out,
   output logic                   pslverr_out,
   // Power mode and pin inputs
   input  wire logic              idle_mode_in,
   input  wire logic              stop_mode_in,
   input  wire logic              slow_clock_mode_in,
   input  wire logic              slow_tick_in,
   input  wire logic              external_reset_pin_n_in,
   // Watchdog outputs
   output logic                   wdog_sys_reset_out,
   output logic                   wdog_cpu_irq_out,
   output logic                   irq_out
);
   initial
   begin
      if (ADDR_W < 12)
         $error("ADDR_W too narrow for register map");
   end

   typedef struct packed {
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
      logic [7:0]  clk_cfg;
      logic        expired;
      logic        reset_flag;
      logic        reset_enable;
      logic [7:0]  ext_ie;
      ta_state_t   ta;
      logic [1:0]  irq_stat;
      logic [1:0]  irq_en;
      logic        sys_reset;
      logic        cpu_irq;
      logic        irq;
   } unit_state_t;

   unit_state_t      cur_ff;
   unit_state_t      nxt_ff;
   logic             pin_level;
   logic             expire;
   logic [CNT_W-1:0] count;
   logic             count_en;
   logic             restart;
   logic             wr_done;
   logic [9:0]       wr_idx;
   logic [2:0]       tsel;

   function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
      logic [9:0] idx;
      idx = a[11:2];
      addr_mapped = (a[1:0] == 2'h0) &&
                    (idx == IDX_CLOCK_CTRL_CFG || idx == IDX_WATCHDOG_CTRL ||
                     idx == IDX_EXT_IRQ_ENABLE || idx == IDX_TIMED_ACCESS ||
                     idx == IDX_IRQ_STATUS || idx == IDX_IRQ_CLEAR ||
                     idx == IDX_IRQ_ENABLE);
   endfunction

   function automatic logic [31:0] read_word(input logic [ADDR_W-1:0] a, input unit_state_t s);
      logic [9:0] idx;
      idx = a[11:2];
      read_word = 32'h0;
      case (idx)
         IDX_CLOCK_CTRL_CFG: read_word = {24'h0, s.clk_cfg};
         IDX_WATCHDOG_CTRL:  read_word = {28'h0, s.expired, s.reset_flag, s.reset_enable, 1'b0};
         IDX_EXT_IRQ_ENABLE: read_word = {24'h0, s.ext_ie};
         IDX_TIMED_ACCESS:   read_word = {31'h0, s.ta == TA_OPEN};
         IDX_IRQ_STATUS:     read_word = {30'h0, s.irq_stat};
         IDX_IRQ_ENABLE:     read_word = {30'h0, s.irq_en};
         default:            read_word = 32'h0;
      endcase
   endfunction

   pin_sync3 u_pin_sync (
      .core_clk_in (core_clk_in),
      .rst_in      (rst_in),
      .pin_in      (external_reset_pin_n_in),
      .level_out   (pin_level)
   );

   assign tsel = {cur_ff.clk_cfg[CK_SEL_TOP], cur_ff.clk_cfg[CK_SEL_HI], cur_ff.clk_cfg[CK_SEL_MID]};

   // Shared with the CPU clock, so halted CPU modes halt the count too
   assign count_en = !idle_mode_in && !stop_mode_in && (!slow_clock_mode_in || slow_tick_in);

   assign wr_done = psel_in && penable_in && pwrite_in && cur_ff.pready;
   assign wr_idx  = paddr_in[11:2];

   // A closed lock swallows the restart without touching the count
   assign restart = wr_done && addr_mapped(paddr_in) && wr_idx == IDX_WATCHDOG_CTRL &&
                    pwdata_in[WC_RESTART] && cur_ff.ta == TA_OPEN;

   wdog_counter #(
      .TIMEOUT_SHRINK (TIMEOUT_SHRINK)
   ) u_counter (
      .core_clk_in (core_clk_in),
      .rst_in      (rst_in),
      .count_en_in (count_en),
      .restart_in  (restart),
      .tsel_in     (tsel),
      .count_out   (count),
      .expire_out  (expire)
   );

   always_comb
   begin
      nxt_ff = cur_ff;

      // Zero-wait slave: ready in every access phase
      nxt_ff.pready  = psel_in && !penable_in;
      nxt_ff.pslverr = psel_in && !penable_in && !addr_mapped(paddr_in);
      if (psel_in && !penable_in && !pwrite_in)
         nxt_ff.prdata = read_word(paddr_in, cur_ff);

      // Timed-access lock: any completed write past the key pair closes it
      if (wr_done)
      begin
         case (cur_ff.ta)
            TA_LOCKED:
               if (wr_idx == IDX_TIMED_ACCESS && pwdata_in[7:0] == TA_KEY_FIRST)
                  nxt_ff.ta = TA_KEYED;
            TA_KEYED:
               if (wr_idx == IDX_TIMED_ACCESS && pwdata_in[7:0] == TA_KEY_SECOND)
                  nxt_ff.ta = TA_OPEN;
               else
                  nxt_ff.ta = TA_LOCKED;
            TA_OPEN:
               nxt_ff.ta = TA_LOCKED;
            default:
               nxt_ff.ta = TA_LOCKED;
         endcase
      end

      if (wr_done && addr_mapped(paddr_in))
      begin
         case (wr_idx)
            IDX_CLOCK_CTRL_CFG:
               nxt_ff.clk_cfg = (pwdata_in[7:0] & CK_WRITE_MASK) | (cur_ff.clk_cfg & ~CK_WRITE_MASK);
            IDX_WATCHDOG_CTRL:
            begin
               if (!pwdata_in[WC_EXPIRED])
                  nxt_ff.expired = 1'b0;
               if (!pwdata_in[WC_RESET_FLAG])
                  nxt_ff.reset_flag = 1'b0;
               nxt_ff.reset_enable = pwdata_in[WC_RESET_ENABLE];
            end
            IDX_EXT_IRQ_ENABLE:
               nxt_ff.ext_ie = pwdata_in[7:0];
            IDX_IRQ_CLEAR:
               nxt_ff.irq_stat = cur_ff.irq_stat & ~pwdata_in[1:0];
            IDX_IRQ_ENABLE:
               nxt_ff.irq_en = pwdata_in[1:0];
            default:
               nxt_ff.irq_en = cur_ff.irq_en;
         endcase
      end

      // External reset pin clears the reset flag
      if (!pin_level)
         nxt_ff.reset_flag = 1'b0;

      // Hardware sets come last so a same-cycle clear loses
      nxt_ff.sys_reset = expire && cur_ff.reset_enable;
      if (expire)
      begin
         nxt_ff.expired = 1'b1;
         nxt_ff.irq_stat[IRQ_EXPIRE] = 1'b1;
      end
      if (expire && cur_ff.reset_enable)
      begin
         nxt_ff.reset_flag = 1'b1;
         nxt_ff.irq_stat[IRQ_RESET] = 1'b1;
      end

      nxt_ff.cpu_irq = nxt_ff.expired && nxt_ff.ext_ie[EIE_WDOG];
      nxt_ff.irq     = |(nxt_ff.irq_stat & nxt_ff.irq_en);
   end

   always_ff @(posedge core_clk_in)
   begin
      if (rst_in)
      begin
         cur_ff              <= '0;
         cur_ff.clk_cfg      <= RST_CLOCK_CTRL_CFG;
         cur_ff.reset_enable <= RST_WATCHDOG_CTRL[WC_RESET_ENABLE];
         cur_ff.ext_ie       <= RST_EXT_IRQ_ENABLE;
         cur_ff.irq_en       <= RST_IRQ_ENABLE;
         cur_ff.ta           <= TA_LOCKED;
      end
      else
         cur_ff <= nxt_ff;
   end

   assign prdata_out         = cur_ff.prdata;
   assign pready_out         = cur_ff.pready;
   assign pslverr_out        = cur_ff.pslverr;
   assign wdog_sys_reset_out = cur_ff.sys_reset;
   assign wdog_cpu_irq_out   = cur_ff.cpu_irq;
   assign irq_out            = cur_ff.irq;

   default clocking chk_clk @(posedge core_clk_in);
   endclocking
   default disable iff (rst_in);

   chk_expiry_sets_flag : assert property (
      expire |=> cur_ff.expired && cur_ff.irq_stat[IRQ_EXPIRE])
      else $error("expiry did not set flag");

   chk_flag_stays_sticky : assert property (
      cur_ff.expired && !(wr_done && wr_idx == IDX_WATCHDOG_CTRL && !pwdata_in[WC_EXPIRED])
      |=> cur_ff.expired)
      else $error("expiry flag dropped without software clear");

   chk_cpu_irq_gated : assert property (
      !cur_ff.ext_ie[EIE_WDOG] && !$past(cur_ff.ext_ie[EIE_WDOG]) |-> !wdog_cpu_irq_out)
      else $error("cpu interrupt without enable");

   chk_reset_follows_expiry : assert property (
      expire && cur_ff.reset_enable |=> wdog_sys_reset_out ##1 !wdog_sys_reset_out)
      else $error("reset pulse missing after enabled expiry");

   chk_no_reset_disabled : assert property (
      expire && !cur_ff.reset_enable |=> !wdog_sys_reset_out)
      else $error("reset issued while disabled");

   chk_reset_sets_flag : assert property (
      wdog_sys_reset_out |-> cur_ff.reset_flag)
      else $error("reset flag not set with watchdog reset");

   chk_restart_needs_lock : assert property (
      restart |-> cur_ff.ta == TA_OPEN ##1 count == '0 && cur_ff.ta == TA_LOCKED)
      else $error("restart without open lock or count kept");

   chk_pin_clears_flag : assert property (
      !pin_level && !expire |=> !cur_ff.reset_flag)
      else $error("pin reset left reset flag set");

   chk_power_up_defaults : assert property (@(posedge core_clk_in)
      $past(rst_in) && !rst_in |-> cur_ff.reset_enable && tsel == 3'h7)
      else $error("power-up defaults wrong");

   chk_apb_ready_pulse : assert property (
      psel_in && !penable_in |=> pready_out ##1 !pready_out || (psel_in && !penable_in))
      else $error("ready not given in access phase");
endmodule

// file: design/wdog_pkg.sv
// Register map, field layout and reset values of the watchdog block
package wdog_pkg;

   // Word indices, byte address is four times the index
   localparam logic [9:0]  IDX_CLOCK_CTRL_CFG  = 10'h08e;
   localparam logic [9:0]  IDX_WATCHDOG_CTRL   = 10'h0d8;
   localparam logic [9:0]  IDX_EXT_IRQ_ENABLE  = 10'h0e8;
   localparam logic [9:0]  IDX_TIMED_ACCESS    = 10'h0c0;
   localparam logic [9:0]  IDX_IRQ_STATUS      = 10'h0f0;
   localparam logic [9:0]  IDX_IRQ_CLEAR       = 10'h0f1;
   localparam logic [9:0]  IDX_IRQ_ENABLE      = 10'h0f2;
   localparam int          ADDR_W              = 12;

   // Reset values
   localparam logic [7:0]  RST_CLOCK_CTRL_CFG  = 8'hc7;
   localparam logic [7:0]  RST_WATCHDOG_CTRL   = 8'h02;
   localparam logic [7:0]  RST_EXT_IRQ_ENABLE  = 8'h00;
   localparam logic [1:0]  RST_IRQ_ENABLE      = 2'h0;

   // Field positions
   localparam int          CK_SEL_HI           = 7;
   localparam int          CK_SEL_MID          = 6;
   localparam int          CK_SEL_TOP          = 2;
   localparam logic [7:0]  CK_WRITE_MASK       = 8'hfc;
   localparam int          WC_EXPIRED          = 3;
   localparam int          WC_RESET_FLAG       = 2;
   localparam int          WC_RESET_ENABLE     = 1;
   localparam int          WC_RESTART          = 0;
   localparam int          EIE_WDOG            = 4;
   localparam int          IRQ_EXPIRE          = 0;
   localparam int          IRQ_RESET           = 1;

   // Timed-access unlock keys
   localparam logic [7:0]  TA_KEY_FIRST        = 8'haa;
   localparam logic [7:0]  TA_KEY_SECOND       = 8'h55;

   // Timeout exponents, count length is two to this power
   localparam int          CNT_W               = 30;
   localparam logic [4:0]  EXP_SEL0            = 5'd17;
   localparam logic [4:0]  EXP_SEL1            = 5'd20;
   localparam logic [4:0]  EXP_SEL2            = 5'd23;
   localparam logic [4:0]  EXP_SEL3            = 5'd26;
   localparam logic [4:0]  EXP_SEL4            = 5'd27;
   localparam logic [4:0]  EXP_SEL5            = 5'd28;
   localparam logic [4:0]  EXP_LONGEST         = EXP_SEL5;

   // Timed-access lock states
   typedef enum logic [2:0] {
      TA_LOCKED = 3'b001,
      TA_KEYED  = 3'b010,
      TA_OPEN   = 3'b100
   } ta_state_t;

endpackage

// file: design/pin_sync3.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module pin_sync3 (
   // Clock and reset
   input  wire logic core_clk_in,
   input  wire logic rst_in,
   // Pin and filtered level
   input  wire logic pin_in,
   output logic      level_out
);
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic level;
   } sync_state_t;

   sync_state_t cur_ff;
   sync_state_t nxt_ff;

   always_comb
   begin
      nxt_ff    = cur_ff;
      nxt_ff.s1 = pin_in;
      nxt_ff.s2 = cur_ff.s1;
      nxt_ff.s3 = cur_ff.s2;
      // Level moves only once stages two and three agree
      if (cur_ff.s2 == cur_ff.s3)
         nxt_ff.level = cur_ff.s3;
   end

   always_ff @(posedge core_clk_in)
   begin
      if (rst_in)
         cur_ff <= 4'hf;
      else
         cur_ff <= nxt_ff;
   end

   assign level_out = cur_ff.level;
endmodule

// file: design/wdog_counter.sv
// Thirty-bit watchdog count with timeout selection and expiry pulse
`timescale 1ns/1ps
module wdog_counter
   import wdog_pkg::*;
#(
   parameter int TIMEOUT_SHRINK = 0
) (
   // Clock and reset
   input  wire logic              core_clk_in,
   input  wire logic              rst_in,
   // Control
   input  wire logic              count_en_in,
   input  wire logic              restart_in,
   input  wire logic [2:0]        tsel_in,
   // Status
   output logic [CNT_W-1:0]       count_out,
   output logic                   expire_out
);
   initial
   begin
      if (TIMEOUT_SHRINK < 0 || TIMEOUT_SHRINK > 16)
         $error("TIMEOUT_SHRINK must lie in 0..16");
   end

   typedef struct packed {
      logic [CNT_W-1:0] cnt;
      logic             expire;
   } cnt_state_t;

   cnt_state_t       cur_ff;
   cnt_state_t       nxt_ff;
   logic [CNT_W-1:0] mask;

   // Unlisted codes fall back to the longest entry
   function automatic logic [4:0] sel_exp(input logic [2:0] sel);
      case (sel)
         3'h0:    sel_exp = EXP_SEL0;
         3'h1:    sel_exp = EXP_SEL1;
         3'h2:    sel_exp = EXP_SEL2;
         3'h3:    sel_exp = EXP_SEL3;
         3'h4:    sel_exp = EXP_SEL4;
         3'h5:    sel_exp = EXP_SEL5;
         default: sel_exp = EXP_LONGEST;
      endcase
   endfunction

   assign mask = (CNT_W'(1) << (sel_exp(tsel_in) - 5'(TIMEOUT_SHRINK))) - CNT_W'(1);

   always_comb
   begin
      nxt_ff        = cur_ff;
      nxt_ff.expire = 1'b0;
      if (restart_in)
         nxt_ff.cnt = '0;
      else if (count_en_in)
      begin
         if ((cur_ff.cnt & mask) == mask)
         begin
            nxt_ff.expire = 1'b1;
            nxt_ff.cnt    = '0;
         end
         else
            nxt_ff.cnt = cur_ff.cnt + CNT_W'(1);
      end
   end

   always_ff @(posedge core_clk_in)
   begin
      if (rst_in)
         cur_ff <= '0;
      else
         cur_ff <= nxt_ff;
   end

   assign count_out  = cur_ff.cnt;
   assign expire_out = cur_ff.expire;

   chk_halted_count_holds : assert property (@(posedge core_clk_in) disable iff (rst_in)
      !count_en_in && !restart_in |=> $stable(cur_ff.cnt))
      else $error("count moved while halted");
   chk_expiry_restarts_zero : assert property (@(posedge core_clk_in) disable iff (rst_in)
      expire_out |-> cur_ff.cnt == '0 || $past(restart_in) || $past(count_en_in))
      else $error("count not restarted on expiry");
endmodule

// file: tb/watchdog_timer_unit_tb.sv
// Self-checking testbench of the watchdog timer unit
`timescale 1ns/1ps
module watchdog_timer_unit_tb;
   import wdog_pkg::*;

   localparam int          SHRINK = 14;
   localparam logic [11:0] A_CK   = {IDX_CLOCK_CTRL_CFG, 2'b00};
   localparam logic [11:0] A_WC   = {IDX_WATCHDOG_CTRL, 2'b00};
   localparam logic [11:0] A_EIE  = {IDX_EXT_IRQ_ENABLE, 2'b00};
   localparam logic [11:0] A_TA   = {IDX_TIMED_ACCESS, 2'b00};
   localparam logic [11:0] A_ST   = {IDX_IRQ_STATUS, 2'b00};
   localparam logic [11:0] A_IC   = {IDX_IRQ_CLEAR, 2'b00};
   localparam logic [11:0] A_IE   = {IDX_IRQ_ENABLE, 2'b00};

   typedef struct {
      logic        wr;
      logic [11:0] a;
      logic [31:0] d;
      logic [31:0] exp;
      logic        err;
   } row_t;

   logic              core_clk_in;
   logic              rst_in;
   logic              psel_in;
   logic              penable_in;
   logic              pwrite_in;
   logic [11:0]       paddr_in;
   logic [31:0]       pwdata_in;
   logic [31:0]       prdata_out;
   logic              pready_out;
   logic              pslverr_out;
   logic              idle_mode_in;
   logic              stop_mode_in;
   logic              slow_clock_mode_in;
   logic              slow_tick_in;
   logic              external_reset_pin_n_in;
   logic              wdog_sys_reset_out;
   logic              wdog_cpu_irq_out;
   logic              irq_out;
   logic              tick_en;
   int                mismatches;
   int                cmp_count;
   int                cyc;
   int                pulses;
   int                last_pulse;
   int                gap;
   int                n;
   logic [31:0]       d;
   logic              e;
   int                codes [6] = '{0, 1, 2, 3, 4, 6};
   row_t              rows [10] = '{
      '{1'b0, A_CK, 32'h0, 32'hc7, 1'b0},
      '{1'b0, A_WC, 32'h0, 32'h02, 1'b0},
      '{1'b0, A_EIE, 32'h0, 32'h00, 1'b0},
      '{1'b0, A_TA, 32'h0, 32'h00, 1'b0},
      '{1'b1, A_ST, 32'h3, 32'h00, 1'b0},
      '{1'b0, A_ST, 32'h0, 32'h00, 1'b0},
      '{1'b0, 12'h004, 32'h0, 32'h00, 1'b1},
      '{1'b1, 12'h239, 32'hff, 32'h00, 1'b1},
      '{1'b1, A_CK, 32'hfc, 32'h00, 1'b0},
      '{1'b0, A_CK, 32'h0, 32'hff, 1'b0}
   };

   watchdog_timer_unit #(
      .TIMEOUT_SHRINK (SHRINK)
   ) u_watchdog_timer_unit (
      .core_clk_in             (core_clk_in),
      .rst_in                  (rst_in),
      .psel_in                 (psel_in),
      .penable_in              (penable_in),
      .pwrite_in               (pwrite_in),
      .paddr_in                (paddr_in),
      .pwdata_in               (pwdata_in),
      .prdata_out              (prdata_out),
      .pready_out              (pready_out),
      .pslverr_out             (pslverr_out),
      .idle_mode_in            (idle_mode_in),
      .stop_mode_in            (stop_mode_in),
      .slow_clock_mode_in      (slow_clock_mode_in),
      .slow_tick_in            (slow_tick_in),
      .external_reset_pin_n_in (external_reset_pin_n_in),
      .wdog_sys_reset_out      (wdog_sys_reset_out),
      .wdog_cpu_irq_out        (wdog_cpu_irq_out),
      .irq_out                 (irq_out)
   );

   always #4 core_clk_in = ~core_clk_in;

   // Pulse monitor, cycle count and hang guard
   always @(posedge core_clk_in)
   begin
      cyc = cyc + 1;
      slow_tick_in <= tick_en && (cyc % 4 == 0);
      if (rst_in === 1'b0 && wdog_sys_reset_out === 1'b1)
      begin
         gap = cyc - last_pulse;
         last_pulse = cyc;
         pulses = pulses + 1;
      end
      if (cyc == 80000)
      begin
         mismatches = mismatches + 1;
         give_verdict();
      end
   end

   function automatic int period(input int c);
      logic [4:0] ex;
      case (c)
         0: ex = EXP_SEL0;
         1: ex = EXP_SEL1;
         2: ex = EXP_SEL2;
         3: ex = EXP_SEL3;
         4: ex = EXP_SEL4;
         5: ex = EXP_SEL5;
         default: ex = EXP_LONGEST;
      endcase
      return 1 << (int'(ex) - SHRINK);
   endfunction

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count = cmp_count + 1;
      if (seen !== exp)
      begin
         mismatches = mismatches + 1;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Request held until pready is seen high at an edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
      @(posedge core_clk_in);
      psel_in <= 1'b1;
      penable_in <= 1'b0;
      pwrite_in <= w;
      paddr_in <= a;
      pwdata_in <= wd;
      @(posedge core_clk_in);
      penable_in <= 1'b1;
      do @(posedge core_clk_in); while (pready_out !== 1'b1);
      rd = prdata_out;
      err = pslverr_out;
      psel_in <= 1'b0;
      penable_in <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] wd);
      logic [31:0] rd;
      logic        err;
      apb(1'b1, a, wd, rd, err);
   endtask

   task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic [31:0] m = 32'hffffffff);
      logic [31:0] rd;
      logic        err;
      apb(1'b0, a, 32'h0, rd, err);
      chk(rd & m, exp);
   endtask

   task automatic unlock();
      wr(A_TA, {24'h0, TA_KEY_FIRST});
      wr(A_TA, {24'h0, TA_KEY_SECOND});
   endtask

   // Restart first, so the old count never overshoots a shorter timeout
   task automatic set_sel(input logic [2:0] c);
      unlock();
      wr(A_WC, 32'h0f);
      wr(A_CK, {24'h0, c[1:0], 3'b000, c[2], 2'b11});
   endtask

   task automatic wait_pulse(input int k);
      int s;
      s = pulses;
      while (pulses < s + k) @(posedge core_clk_in);
   endtask

   task automatic quiet(input int cycles);
      repeat (3) @(posedge core_clk_in);
      n = pulses;
      repeat (cycles) @(posedge core_clk_in);
   endtask

   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   initial
   begin
      core_clk_in = 1'b0;
      rst_in = 1'b1;
      {psel_in, penable_in, pwrite_in, idle_mode_in, stop_mode_in} = 5'h0;
      {slow_clock_mode_in, tick_en} = 2'h0;
      paddr_in = 12'h0;
      pwdata_in = 32'h0;
      external_reset_pin_n_in = 1'b1;
      {mismatches, cmp_count, cyc, pulses, last_pulse, gap} = '0;
      repeat (16) @(posedge core_clk_in);
      rst_in <= 1'b0;
      foreach (rows[i])
      begin
         apb(rows[i].wr, rows[i].a, rows[i].d, d, e);
         chk({31'h0, e}, {31'h0, rows[i].err});
         if (!rows[i].wr)
            chk(d, rows[i].exp);
      end
      foreach (codes[i])
      begin
         set_sel(codes[i][2:0]);
         wait_pulse(1);
         wait_pulse(1);
         chk(gap, period(codes[i]));
      end
      rd_chk(A_WC, 32'h0e);
      chk({31'h0, wdog_cpu_irq_out}, 32'h0);
      wr(A_EIE, 32'h10);
      repeat (3) @(posedge core_clk_in);
      chk({31'h0, wdog_cpu_irq_out}, 32'h1);
      rd_chk(A_ST, 32'h3);
      chk({31'h0, irq_out}, 32'h0);
      wr(A_IE, 32'h1);
      repeat (3) @(posedge core_clk_in);
      chk({31'h0, irq_out}, 32'h1);
      wr(A_IC, 32'h1);
      repeat (3) @(posedge core_clk_in);
      chk({31'h0, irq_out}, 32'h0);
      rd_chk(A_ST, 32'h2);
      wr(A_IE, 32'h3);
      repeat (3) @(posedge core_clk_in);
      chk({31'h0, irq_out}, 32'h1);
      wr(A_IC, 32'h2);
      repeat (3) @(posedge core_clk_in);
      chk({31'h0, irq_out}, 32'h0);
      rd_chk(A_ST, 32'h0);
      wr(A_WC, 32'h0b);
      rd_chk(A_WC, 32'h0a);
      wr(A_WC, 32'h02);
      repeat (3) @(posedge core_clk_in);
      rd_chk(A_WC, 32'h02);
      chk({31'h0, wdog_cpu_irq_out}, 32'h0);
      // Locked restart must not disturb the period
      set_sel(3'd1);
      wait_pulse(1);
      wr(A_WC, 32'h0f);
      wait_pulse(1);
      chk(gap, period(1));
      wait_pulse(1);
      unlock();
      rd_chk(A_TA, 32'h1);
      wr(A_WC, 32'h0f);
      rd_chk(A_TA, 32'h0);
      wait_pulse(1);
      chk({31'h0, gap > period(1)}, 32'h1);
      set_sel(3'd0);
      wr(A_WC, 32'h00);
      quiet(40);
      chk(pulses, n);
      rd_chk(A_WC, 32'h08);
      wr(A_WC, 32'h02);
      wait_pulse(1);
      wr(A_WC, 32'h04);
      rd_chk(A_WC, 32'h04, 32'h04);
      external_reset_pin_n_in <= 1'b0;
      repeat (6) @(posedge core_clk_in);
      external_reset_pin_n_in <= 1'b1;
      repeat (6) @(posedge core_clk_in);
      rd_chk(A_WC, 32'h00, 32'h04);
      wr(A_WC, 32'h02);
      idle_mode_in <= 1'b1;
      quiet(40);
      chk(pulses, n);
      idle_mode_in <= 1'b0;
      stop_mode_in <= 1'b1;
      quiet(40);
      chk(pulses, n);
      stop_mode_in <= 1'b0;
      slow_clock_mode_in <= 1'b1;
      tick_en <= 1'b1;
      wait_pulse(2);
      wait_pulse(1);
      chk(gap, 4 * period(0));
      slow_clock_mode_in <= 1'b0;
      tick_en <= 1'b0;
      // Second reset in mid-run
      rst_in <= 1'b1;
      repeat (16) @(posedge core_clk_in);
      rst_in <= 1'b0;
      @(posedge core_clk_in);
      chk({31'h0, wdog_cpu_irq_out}, 32'h0);
      chk({31'h0, irq_out}, 32'h0);
      chk({31'h0, wdog_sys_reset_out}, 32'h0);
      rd_chk(A_CK, 32'hc7);
      rd_chk(A_WC, 32'h02);
      give_verdict();
   end
endmodule
